// ---- logic/adgc_ctrl.sv ----
// Converter control: bus registers, front-end selection, sequencing and result bytes.
`timescale 1ns/1ps
`include "adgc_regs.svh"

module adgc_ctrl (
    input  wire logic        clk_sys_i,      // System clock, 20 MHz.
    input  wire logic        resetn_i,       // Asynchronous reset, active low.
    input  wire logic [31:0] bus_addr_i,     // Processor byte address.
    input  wire logic        bus_wr_i,       // Write strobe, one cycle.
    input  wire logic        bus_rd_i,       // Read strobe, one cycle.
    input  wire logic [7:0]  bus_wdata_i,    // Write data.
    output logic      [7:0]  bus_rdata_o,    // Read data, valid the cycle after the strobe.
    input  wire logic        adc_done_i,     // Converter end of conversion pulse.
    input  wire logic [15:0] adc_data_i,     // Converter output word.
    input  wire logic        adc_wide_i,     // High when the 16-bit converter is fitted.
    output logic             adc_convert_o,  // Start pulse to the converter.
    output logic      [3:0]  gain_code_o,    // Gain code to the amplifiers.
    output logic             bipolar_o,      // High selects bipolar range.
    output logic      [3:0]  mux_pos_o,      // Positive multiplexer channel.
    output logic      [3:0]  mux_neg_o,      // Negative multiplexer channel.
    output logic             input_mode_o,   // High selects differential input.
    output logic             busy_n_o,       // Low while a conversion runs.
    output logic             irq_o,          // Completion interrupt request.
    output logic             timeout_o       // Last conversion ended without converter done.
);

    // A strobe is taken on the rising edge that sees it. Written settings reach the
    // front-end outputs at that same edge, and read data stands for one cycle only.
    // The three registers are write-only; reads at the channel and gain addresses return
    // the result bytes, so polling the result never disturbs the front-end settings.
    // The result is stored as delivered, upper four bits cleared for the narrow converter. The converter hands over the
    // word it took at the previous start, so a new channel or gain needs two starts.
    // Settings are not locked during a conversion, so a host may switch the front end
    // while busy and let it settle before the next start.
    // A converter that never reports done is cut off one cycle short of the longest conversion time.
    // Busy then returns high with the old result kept and the timeout flag raised, which
    // trades a stale word for a host that can never hang on the busy flag.

    adgc_pkg::adgc_ctl_t c_r;
    adgc_pkg::adgc_ctl_t c_nxt;

    logic seq_convert;
    logic seq_busy_n;
    logic seq_irq;
    logic seq_complete;
    logic seq_timed_out;
    logic start_req;
    logic [1:0] wr_cfg;

    // Full address compare; it serves the write decodes only, reads are decoded in read_byte.
    function automatic logic addr_hit(input logic [31:0] addr, input logic [31:0] target);
        addr_hit = (addr == target);
    endfunction : addr_hit

    // Drops the four upper result bits when the narrow converter is fitted.
    function automatic logic [15:0] fit_result(input logic [15:0] raw, input logic wide);
        fit_result = wide ? raw : {4'h0, raw[11:0]};
    endfunction : fit_result

    // Positive multiplexer input: a pair takes its low-bank member, bit 3 is ignored.
    function automatic logic [3:0] pos_of(input logic [7:0] sel);
        if (sel[`ADGC_DIFF_BIT])
        begin
            pos_of = {1'b0, sel[`ADGC_PAIR_MSB:`ADGC_CHAN_LSB]};
        end
        else
        begin
            pos_of = sel[`ADGC_CHAN_MSB:`ADGC_CHAN_LSB];
        end
    endfunction : pos_of

    // Negative multiplexer input: the high-bank partner of a pair, else channel 0.
    function automatic logic [3:0] neg_of(input logic [7:0] sel);
        if (sel[`ADGC_DIFF_BIT])
        begin
            neg_of = {1'b0, sel[`ADGC_PAIR_MSB:`ADGC_CHAN_LSB]} + `ADGC_DIFF_NEG_OFS;
        end
        else
        begin
            neg_of = 4'h0;
        end
    endfunction : neg_of

    // Result byte behind a read address; any other address reads as zero.
    function automatic logic [7:0] read_byte(input logic [31:0] addr, input logic [15:0] res);
        case (addr)
            `ADGC_ADDR_CHAN:
            begin
                read_byte = res[7:0];
            end
            `ADGC_ADDR_GAIN:
            begin
                read_byte = res[15:8];
            end
            default:
            begin
                read_byte = 8'h00;
            end
        endcase
    endfunction : read_byte

    // Unity gain, unipolar, single-ended channel 0, interrupt off and a zero result.
    localparam adgc_pkg::adgc_ctl_t CTL_RST = '{
        gain_reg:  `ADGC_GAIN_RST,
        chan_reg:  `ADGC_CHAN_RST,
        result:    `ADGC_RESULT_RST,
        rdata:     8'h00,
        pos_chan:  4'h0,
        neg_chan:  4'h0,
        diff_mode: 1'b0,
        gain_code: 4'h0,
        bipolar:   1'b0
    };

    assign start_req = bus_wr_i && addr_hit(bus_addr_i, `ADGC_ADDR_START);

    // One write decoder per setting register; only the two setting registers repeat.
    localparam int          CFG_GAIN = 0;
    localparam int          CFG_CHAN = 1;
    localparam logic [31:0] CFG_ADDR [2] = '{`ADGC_ADDR_GAIN, `ADGC_ADDR_CHAN};
    genvar g;
    generate
        for (g = 0; g < 2; g++)
        begin : g_cfg_wr
            assign wr_cfg[g] = bus_wr_i && addr_hit(bus_addr_i, CFG_ADDR[g]);
        end
    endgenerate

    adgc_conv_seq u_seq (
        .clk_sys_i   (clk_sys_i),
        .resetn_i    (resetn_i),
        .start_i     (start_req),
        .irq_en_i    (c_r.chan_reg[`ADGC_IRQ_EN_BIT]),
        .adc_done_i  (adc_done_i),
        .convert_o   (seq_convert),
        .busy_n_o    (seq_busy_n),
        .irq_o       (seq_irq),
        .complete_o  (seq_complete),
        .timed_out_o (seq_timed_out)
    );

    always_comb
    begin
        c_nxt = c_r;
        // Writes take effect at once so the front end settles before the next start.
        if (wr_cfg[CFG_GAIN])
        begin
            c_nxt.gain_reg = bus_wdata_i;
        end
        if (wr_cfg[CFG_CHAN])
        begin
            c_nxt.chan_reg = bus_wdata_i;
        end
        c_nxt.gain_code = c_nxt.gain_reg[`ADGC_GAIN_MSB:`ADGC_GAIN_LSB];
        c_nxt.bipolar   = c_nxt.gain_reg[`ADGC_BIPOLAR_BIT];
        c_nxt.diff_mode = c_nxt.chan_reg[`ADGC_DIFF_BIT];
        c_nxt.pos_chan  = pos_of(c_nxt.chan_reg);
        c_nxt.neg_chan  = neg_of(c_nxt.chan_reg);
        // The converter hands out the word it sampled at the previous start, sign bit
        // included, so the result register keeps what each completion delivers, less the upper four bits on the narrow converter.
        if (seq_complete)
        begin
            c_nxt.result = fit_result(adc_data_i, adc_wide_i);
        end
        c_nxt.rdata = 8'h00;
        if (bus_rd_i)
        begin
            c_nxt.rdata = read_byte(bus_addr_i, c_r.result);
        end
    end

    always_ff @(posedge clk_sys_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            c_r <= CTL_RST;
        end
        else
        begin
            c_r <= c_nxt;
        end
    end

    // Front-end settings and read data, each straight from its register.
    assign bus_rdata_o   = c_r.rdata;
    assign gain_code_o   = c_r.gain_code;
    assign bipolar_o     = c_r.bipolar;
    assign mux_pos_o     = c_r.pos_chan;
    assign mux_neg_o     = c_r.neg_chan;
    assign input_mode_o  = c_r.diff_mode;
    // Sequencer outputs leave its own registers without further logic.
    assign adc_convert_o = seq_convert;
    assign busy_n_o      = seq_busy_n;
    assign irq_o         = seq_irq;
    assign timeout_o     = seq_timed_out;

endmodule : adgc_ctrl

// ---- pkg/adgc_regs.svh ----
// Register addresses, field positions, reset values and timing counts for the converter control.
`ifndef ADGC_REGS_SVH
`define ADGC_REGS_SVH

// Bus addresses of the three write registers; the two upper ones also return result bytes.
`define ADGC_ADDR_START      32'h0600_0290
`define ADGC_ADDR_CHAN       32'h0600_0298
`define ADGC_ADDR_GAIN       32'h0600_02A0

// Gain and polarity register fields.
`define ADGC_GAIN_LSB        0
`define ADGC_GAIN_MSB        3
`define ADGC_BIPOLAR_BIT     7

// Channel, mode and interrupt register fields.
`define ADGC_CHAN_LSB        0
`define ADGC_CHAN_MSB        3
`define ADGC_PAIR_MSB        2
`define ADGC_DIFF_BIT        4
`define ADGC_IRQ_EN_BIT      7

// In a differential pair the negative input is the positive channel plus this offset.
`define ADGC_DIFF_NEG_OFS    4'h8

// Unity gain, unipolar, single ended channel 0 and interrupt disabled after reset.
`define ADGC_GAIN_RST        8'h00
`define ADGC_CHAN_RST        8'h00
`define ADGC_RESULT_RST      16'h0000

// Highest gain code in use; codes above it are kept but have no table entry.
`define ADGC_GAIN_CODE_MAX   4'hB

// Timing: clock period and longest conversion time, both in nanoseconds.
`define ADGC_CLK_PERIOD_NS   50
`define ADGC_CONV_MAX_NS     10000
`define ADGC_CONV_MAX_CYC    (`ADGC_CONV_MAX_NS / `ADGC_CLK_PERIOD_NS)

// Host-side wait after a channel or gain change before the next start, in nanoseconds.
`define ADGC_SETTLE_NS       30000
`define ADGC_SETTLE_CYC      (`ADGC_SETTLE_NS / `ADGC_CLK_PERIOD_NS)
`define ADGC_TMR_W           8

`endif

// ---- pkg/adgc_pkg.sv ----
// Types shared by the converter control and its conversion sequencer.
package adgc_pkg;

    typedef enum logic [1:0] {
        SEQ_IDLE,
        SEQ_CONVERT
    } adgc_seq_state_t;

    typedef struct packed {
        adgc_seq_state_t state;
        logic [7:0]      timer;
        logic            convert;
        logic            busy_n;
        logic            irq;
        logic            complete;
        logic            timed_out;
    } adgc_seq_t;

    typedef struct packed {
        logic [7:0]  gain_reg;
        logic [7:0]  chan_reg;
        logic [15:0] result;
        logic [7:0]  rdata;
        logic [3:0]  pos_chan;
        logic [3:0]  neg_chan;
        logic        diff_mode;
        logic [3:0]  gain_code;
        logic        bipolar;
    } adgc_ctl_t;

endpackage : adgc_pkg

// ---- logic/adgc_conv_seq.sv ----
// Conversion sequencer: start pulse, busy flag, timeout and completion interrupt.
`timescale 1ns/1ps
`include "adgc_regs.svh"

module adgc_conv_seq (
    input  wire logic clk_sys_i,    // System clock, 20 MHz.
    input  wire logic resetn_i,     // Asynchronous reset, active low.
    input  wire logic start_i,      // One-cycle request to start a conversion.
    input  wire logic irq_en_i,     // Interrupt enable level.
    input  wire logic adc_done_i,   // Converter reports end of conversion.
    output logic      convert_o,    // One-cycle start pulse to the converter.
    output logic      busy_n_o,     // Low while a conversion runs.
    output logic      irq_o,        // Completion interrupt request.
    output logic      complete_o,   // One-cycle pulse: converter data valid.
    output logic      timed_out_o   // Last conversion ended by timeout.
);

    adgc_pkg::adgc_seq_t s_r;
    adgc_pkg::adgc_seq_t s_nxt;

    localparam logic [7:0] CONV_MAX_CYC = 8'(`ADGC_CONV_MAX_CYC);

    always_comb
    begin
        s_nxt          = s_r;
        s_nxt.convert  = 1'b0;
        s_nxt.complete = 1'b0;
        case (s_r.state)
            adgc_pkg::SEQ_IDLE:
            begin
                // A write to the start register while busy is ignored.
                if (start_i)
                begin
                    s_nxt.state     = adgc_pkg::SEQ_CONVERT;
                    s_nxt.convert   = 1'b1;
                    s_nxt.busy_n    = 1'b0;
                    s_nxt.irq       = 1'b0;
                    s_nxt.timed_out = 1'b0;
                    s_nxt.timer     = 8'h00;
                end
            end
            adgc_pkg::SEQ_CONVERT:
            begin
                s_nxt.timer = s_r.timer + 8'h01;
                // The conversion is forced to end so busy never exceeds the limit.
                if (adc_done_i || (s_r.timer == CONV_MAX_CYC - 8'h02))
                begin
                    s_nxt.state     = adgc_pkg::SEQ_IDLE;
                    s_nxt.busy_n    = 1'b1;
                    s_nxt.complete  = adc_done_i;
                    s_nxt.timed_out = !adc_done_i;
                    s_nxt.irq       = irq_en_i;
                end
            end
            default:
            begin
                s_nxt.state  = adgc_pkg::SEQ_IDLE;
                s_nxt.busy_n = 1'b1;
            end
        endcase
    end

    always_ff @(posedge clk_sys_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            s_r <= '{state: adgc_pkg::SEQ_IDLE, timer: 8'h00, convert: 1'b0,
                     busy_n: 1'b1, irq: 1'b0, complete: 1'b0, timed_out: 1'b0};
        end
        else
        begin
            s_r <= s_nxt;
        end
    end

    assign convert_o   = s_r.convert;
    assign busy_n_o    = s_r.busy_n;
    assign irq_o       = s_r.irq;
    assign complete_o  = s_r.complete;
    assign timed_out_o = s_r.timed_out;

endmodule : adgc_conv_seq

// ---- test/adgc_ctrl_assertions.sv ----
// Port checker for the converter control, bound to its top module.
`timescale 1ns/1ps
`include "adgc_regs.svh"
module adgc_ctrl_chk (
    input wire logic        clk_sys_i,     // Clock.
    input wire logic        resetn_i,      // Reset.
    input wire logic [31:0] bus_addr_i,    // Address.
    input wire logic        bus_wr_i,      // Write.
    input wire logic [7:0]  bus_wdata_i,   // Data.
    input wire logic        adc_done_i,    // Done.
    input wire logic        adc_convert_o, // Start.
    input wire logic [3:0]  gain_code_o,   // Gain.
    input wire logic        bipolar_o,     // Range.
    input wire logic [3:0]  mux_pos_o,     // Plus.
    input wire logic [3:0]  mux_neg_o,     // Minus.
    input wire logic        input_mode_o,  // Mode.
    input wire logic        busy_n_o,      // Busy.
    input wire logic        irq_o          // Interrupt.
);
    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (!resetn_i);
    sequence s_start;
        bus_wr_i && bus_addr_i == `ADGC_ADDR_START;
    endsequence
    a_start_run: assert property (s_start ##0 busy_n_o
        |=> adc_convert_o && !busy_n_o) else $error("Start not taken.");
    a_start_busy: assert property (s_start ##0 !busy_n_o
        |=> !adc_convert_o) else $error("Start taken while busy.");
    a_conv_bound: assert property ($fell(busy_n_o) |-> ##[1:200] busy_n_o)
        else $error("Conversion too long.");
    a_done_ends: assert property (!busy_n_o && adc_done_i |=> busy_n_o)
        else $error("Busy kept after done.");
    a_irq_rise: assert property ($rose(irq_o) |-> $rose(busy_n_o))
        else $error("Interrupt off completion.");
    a_irq_clear: assert property (adc_convert_o |-> !irq_o)
        else $error("Interrupt kept at start.");
    a_gain_set: assert property (bus_wr_i && bus_addr_i == `ADGC_ADDR_GAIN
        |=> {bipolar_o, 3'h0, gain_code_o} == ($past(bus_wdata_i) & 8'h8F))
        else $error("Gain write lost.");
    a_mux_map: assert property (input_mode_o ? mux_neg_o == mux_pos_o + 4'h8
        && !mux_pos_o[3] : mux_neg_o == 4'h0) else $error("Bad channel pair.");
endmodule : adgc_ctrl_chk
bind adgc_ctrl adgc_ctrl_chk i_adgc_ctrl_chk (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i),
    .bus_addr_i(bus_addr_i), .bus_wr_i(bus_wr_i), .bus_wdata_i(bus_wdata_i),
    .adc_done_i(adc_done_i), .adc_convert_o(adc_convert_o), .gain_code_o(gain_code_o),
    .bipolar_o(bipolar_o), .mux_pos_o(mux_pos_o), .mux_neg_o(mux_neg_o),
    .input_mode_o(input_mode_o), .busy_n_o(busy_n_o), .irq_o(irq_o));

// ---- test/adgc_conv_model.sv ----
// Converter model: returns the previous sample after a fixed conversion time.
`timescale 1ns/1ps
module adgc_conv_model #(
    parameter int DLY = 160 // Cycles per conversion.
) (
    input  wire logic        clk_sys_i, // Clock.
    input  wire logic        resetn_i,  // Reset.
    input  wire logic        convert_i, // Start pulse.
    input  wire logic        mute_i,    // Never report done.
    input  wire logic [15:0] sample_i,  // Input sampled.
    output logic             done_o,    // Done pulse.
    output logic      [15:0] data_o     // Result word.
);
    logic [15:0] held_r;
    logic [15:0] out_r;
    int          cnt_r;
    always_ff @(posedge clk_sys_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            {held_r, out_r, done_o, data_o} <= '0;
            cnt_r <= 0;
        end
        else
        begin
            done_o <= cnt_r == 1 && !mute_i;
            // Outside the done window the word toggles so stale data never looks valid.
            data_o <= (cnt_r == 1 || done_o) ? out_r : ~data_o;
            cnt_r  <= cnt_r > 0 ? cnt_r - 1 : 0;
            if (convert_i)
            begin
                {out_r, held_r} <= {held_r, sample_i};
                cnt_r <= DLY;
            end
        end
    end
endmodule : adgc_conv_model

// ---- test/adgc_ctrl_test.sv ----
// Bench: register writes, conversions and result reads on the converter control.
`timescale 1ns/1ps
`include "adgc_regs.svh"
module adgc_ctrl_test;
    logic        clk_sys_i = 1'b0;
    logic        resetn_i  = 1'b0;
    logic        wr = 1'b0, rd = 1'b0, wide = 1'b1, mute = 1'b0;
    logic [31:0] addr = 32'h0;
    logic [7:0]  wdata = 8'h00, rdata, q, v;
    logic [15:0] sample = 16'h0000, data, w;
    logic [3:0]  gain, pos, neg;
    logic        done, conv, bip, mode, busy_n, irq, tmo;
    int          err_count = 0, tests_run = 0, ncv = 0, k;
    always #25 clk_sys_i = ~clk_sys_i;
    always @(posedge clk_sys_i) if (conv === 1'b1) ncv++;
    adgc_ctrl i_adgc_ctrl (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .bus_addr_i(addr),
        .bus_wr_i(wr), .bus_rd_i(rd), .bus_wdata_i(wdata), .bus_rdata_o(rdata),
        .adc_done_i(done), .adc_data_i(data), .adc_wide_i(wide), .adc_convert_o(conv),
        .gain_code_o(gain), .bipolar_o(bip), .mux_pos_o(pos), .mux_neg_o(neg),
        .input_mode_o(mode), .busy_n_o(busy_n), .irq_o(irq), .timeout_o(tmo));
    adgc_conv_model i_adgc_conv_model (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i),
        .convert_i(conv), .mute_i(mute), .sample_i(sample), .done_o(done), .data_o(data));
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            err_count++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task automatic results;
        $display("checks %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : results
    task automatic bus(input logic we, input logic [31:0] a, input logic [7:0] d);
        @(posedge clk_sys_i);
        #2 addr = a;
        wdata = d;
        wr = we;
        rd = !we;
        @(posedge clk_sys_i);
        #2 wr = 1'b0;
        rd = 1'b0;
        q = rdata;
    endtask : bus
    // The second start lands while busy and must be dropped.
    task automatic run(input logic [15:0] s);
        int i;
        sample = s;
        bus(1'b1, `ADGC_ADDR_START, 8'h00);
        bus(1'b1, `ADGC_ADDR_START, 8'h00);
        for (i = 0; i < 300 && busy_n !== 1'b1; i++)
            @(posedge clk_sys_i) #2;
        if (i == 300)
        begin
            err_count++;
            results();
        end
        check({15'h0000, i <= `ADGC_CONV_MAX_CYC - 2}, 16'h0001);
        bus(1'b0, `ADGC_ADDR_CHAN, 8'h00);
        w[7:0] = q;
        bus(1'b0, `ADGC_ADDR_GAIN, 8'h00);
        w[15:8] = q;
    endtask : run
    initial
    begin
        repeat (3) @(posedge clk_sys_i);
        #2 resetn_i = 1'b1;
        check({busy_n, irq, tmo, bip, gain, pos, neg}, 16'h8000);
        for (k = 0; k < 24; k++)
        begin
            v = k[7:0];
            bus(1'b1, `ADGC_ADDR_GAIN, {v[0], 3'h0, v[3:0]});
            check({11'h000, bip, gain}, {11'h000, v[0], v[3:0]});
            bus(1'b1, `ADGC_ADDR_CHAN, v);
            check({3'h0, mode, pos, neg, 4'h0}, {3'h0, v[4], v[4] ? {1'b0, v[2:0]} : v[3:0],
                v[4] ? {1'b1, v[2:0]} : 4'h0, 4'h0});
        end
        bus(1'b1, `ADGC_ADDR_CHAN, 8'h90);
        repeat (`ADGC_SETTLE_CYC) @(posedge clk_sys_i) #2;
        run(16'h8123);
        check(w, 16'h0000);
        check({15'h0000, irq}, 16'h0001);
        run(16'hA5C3);
        check(w, 16'h8123);
        wide = 1'b0;
        bus(1'b1, `ADGC_ADDR_CHAN, 8'h05);
        repeat (`ADGC_SETTLE_CYC) @(posedge clk_sys_i) #2;
        run(16'h1234);
        check(w, 16'h05C3);
        check({15'h0000, irq}, 16'h0000);
        wide = 1'b1;
        mute = 1'b1;
        run(16'h4321);
        check(w, 16'h05C3);
        check({15'h0000, tmo}, 16'h0001);
        check(ncv[15:0], 16'h0004);
        bus(1'b0, 32'h0600_02A8, 8'h00);
        check({8'h00, q}, 16'h0000);
        results();
    end
endmodule : adgc_ctrl_test
